// ### verilog/srap_consts.svh
`ifndef SRAP_CONSTS_SVH
`define SRAP_CONSTS_SVH

// ==========================================================================
// frame layout
// ==========================================================================
`define SRAP_START        4'hC
`define SRAP_LEAD         4'h0
`define SRAP_PAD_ID       2'h0
`define SRAP_GAP_BIT      1'h0
`define SRAP_END_BIT      1'h0
`define SRAP_RD_FILL      8'h00
`define SRAP_FRAME_W      36

// operation_select_field codes
`define SRAP_OP_TW        2'h0
`define SRAP_OP_BW        2'h1
`define SRAP_OP_TR        2'h2
`define SRAP_OP_FR        2'h3

// ==========================================================================
// device bit index within a transaction (0 = first start bit)
// ==========================================================================
`define SRAP_IDX_BODY     5'h04
`define SRAP_IDX_OP_END   5'h05
`define SRAP_IDX_ID_END   5'h0D
`define SRAP_IDX_ADR_END  5'h15
`define SRAP_IDX_GAP      5'h16
`define SRAP_IDX_DAT_END  5'h1E
`define SRAP_IDX_LAST     5'h1F
`define SRAP_IDX_ZERO     5'h00
`define SRAP_IDX_ONE      5'h01

// ==========================================================================
// controller frame position (4 lead-in periods, then 32 bits)
// ==========================================================================
`define SRAP_POS_ZERO     6'h00
`define SRAP_POS_ONE      6'h01
`define SRAP_POS_RD_FIRST 6'h1C
`define SRAP_POS_LAST     6'h23

`define SRAP_BYTE_ZERO    8'h00
`define SRAP_ID_ZERO      6'h00

`endif

// ### verilog/srap_pkg.sv
package srap_pkg;
  `include "srap_consts.svh"

  // ========================================================================
  // types
  // ========================================================================
  typedef enum logic [1:0] {
    SRAP_TARGETED_WRITE  = `SRAP_OP_TW,
    SRAP_BROADCAST_WRITE = `SRAP_OP_BW,
    SRAP_TARGETED_READ   = `SRAP_OP_TR,
    SRAP_FORCED_READ     = `SRAP_OP_FR
  } srap_op_t;

  typedef enum logic [5:0] {
    SRAP_D_IDLE = 6'h01,
    SRAP_D_BODY = 6'h02,
    SRAP_D_RDAT = 6'h04,
    SRAP_D_PASS = 6'h08,
    SRAP_D_WDAT = 6'h10,
    SRAP_D_TAIL = 6'h20
  } srap_dev_state_t;

  typedef enum logic [1:0] {
    SRAP_H_IDLE = 2'h1,
    SRAP_H_RUN  = 2'h2
  } srap_host_state_t;
endpackage

// ### verilog/srap_link_if.sv
// serial management link between controller and device
interface srap_link_if;
  logic link_sck;
  logic link_cmd;
  logic link_rst;
  logic chain_input_pin;
  logic chain_output_pin;
  logic chain_output_oe;
  logic chain_line;

  // undriven chain output reads as low (weak pull-down)
  assign chain_line = chain_output_oe & chain_output_pin;

  modport dev (
    input  link_sck,
    input  link_cmd,
    input  link_rst,
    input  chain_input_pin,
    output chain_output_pin,
    output chain_output_oe
  );

  modport host (
    output link_sck,
    output link_cmd,
    output link_rst,
    output chain_input_pin,
    input  chain_line
  );
endinterface

// ### verilog/srap_dev.sv
// Functional notes
// RL1 - five pins: clock, command, chain in, out, reset
// RL2 - pins sampled at serial clock falling edge
// RL3 - 32-edge transactions, next from S36 on
// RL4 - serial clock may idle between transactions
// RL5 - start pattern 1100 then 28 body bits
// RL6 - two-bit operation field selects operation
// RL7 - two zeros then six-bit device identifier
// RL8 - eight-bit register address follows identifier
// RL9 - one zero gap bit for access
// RL10 - write sends eight data bits, stored
// RL11 - controller ends write with zero bit
// RL12 - targeted write on match, broadcast always
// RL13 - chain pins unused during writes
// RL14 - read: zero command bits, data out
// RL15 - read MSB first, after s26, sampled s27
// RL16 - controller ends read with zero bit
// RL17 - forced read answers regardless of identifier
// RL18 - mismatched read copies chain in to out
// RL19 - registers eight bits, reserved written zero
// RL20 - own identifier loaded at init, compared
// RL21 - release driver, rearm after transaction
`include "srap_consts.svh"
module srap_dev
  import srap_pkg::*;
(
  srap_link_if.dev          link,
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  input  wire logic [5:0]   id_strap,
  output logic              wr_strobe,
  output logic [7:0]        wr_addr,
  output logic [7:0]        wr_data
);

  // ========================================================================
  // link-domain state (clocked on falling serial clock edges)
  // ========================================================================
  srap_dev_state_t state_reg;
  logic [4:0]      idx_reg;
  logic [2:0]      hist_reg;
  logic [7:0]      shift_reg;
  srap_op_t        op_reg;
  logic [5:0]      rx_id_reg;
  logic [7:0]      adr_reg;
  logic [7:0]      out_reg;
  logic            sdo_reg;
  logic            oe_reg;
  logic [5:0]      own_id_reg;
  logic [5:0]      strap_s1_reg;
  logic [5:0]      strap_s2_reg;
  logic            wr_tog_reg;
  logic [7:0]      lat_adr_reg;
  logic [7:0]      lat_dat_reg;
  logic [7:0]      regs [0:255];

  logic            id_match;
  logic            mem_we;
  logic [7:0]      rx_byte;

  // byte assembled including the bit sampled on this edge
  assign rx_byte  = {shift_reg[6:0], link.link_cmd};
  assign id_match = (rx_id_reg == own_id_reg);
  // data complete on last data edge; targeted needs match
  assign mem_we   = (state_reg == SRAP_D_WDAT) && (idx_reg == `SRAP_IDX_DAT_END)
                    && ((op_reg == SRAP_BROADCAST_WRITE)
                        || ((op_reg == SRAP_TARGETED_WRITE) && id_match)); // RL12

  // ========================================================================
  // strap synchroniser into the link domain
  // ========================================================================
  // straps are static but come from another domain, so two flops first
  always_ff @(negedge link.link_sck or negedge arst_n) begin
    if (!arst_n) begin
      strap_s1_reg <= `SRAP_ID_ZERO;
      strap_s2_reg <= `SRAP_ID_ZERO;
    end else begin
      strap_s1_reg <= id_strap;
      strap_s2_reg <= strap_s1_reg;
    end
  end

  // own identifier: caught while the reset pin is seen high
  always_ff @(negedge link.link_sck or negedge arst_n) begin
    if (!arst_n) begin
      own_id_reg <= `SRAP_ID_ZERO;
    end else if (link.link_rst) begin
      own_id_reg <= strap_s2_reg; // RL20 RL1
    end
  end

  // ========================================================================
  // transaction sequencer
  // ========================================================================
  // all pins sampled on the falling edge; no rising edge is used, so a
  // stopped clock simply freezes the sequencer between frames
  always_ff @(negedge link.link_sck or negedge arst_n) begin // RL2 RL4
    if (!arst_n) begin
      state_reg <= SRAP_D_IDLE;
      idx_reg   <= `SRAP_IDX_ZERO;
      hist_reg  <= 3'h0;
    end else if (link.link_rst) begin
      state_reg <= SRAP_D_IDLE;
      idx_reg   <= `SRAP_IDX_ZERO;
      hist_reg  <= 3'h0;
    end else begin
      unique case (state_reg)
        SRAP_D_IDLE: begin
          hist_reg <= {hist_reg[1:0], link.link_cmd};
          if ({hist_reg, link.link_cmd} == `SRAP_START) begin // RL5 RL3
            state_reg <= SRAP_D_BODY;
            idx_reg   <= `SRAP_IDX_BODY;
          end
        end
        SRAP_D_BODY: begin
          idx_reg <= idx_reg + `SRAP_IDX_ONE;
          if (idx_reg == `SRAP_IDX_GAP) begin // RL9
            if (op_reg == SRAP_FORCED_READ
                || (op_reg == SRAP_TARGETED_READ && id_match)) begin
              state_reg <= SRAP_D_RDAT; // RL17
            end else if (op_reg == SRAP_TARGETED_READ) begin
              state_reg <= SRAP_D_PASS; // RL18
            end else begin
              state_reg <= SRAP_D_WDAT; // RL10
            end
          end
        end
        SRAP_D_RDAT, SRAP_D_PASS, SRAP_D_WDAT: begin
          idx_reg <= idx_reg + `SRAP_IDX_ONE;
          if (idx_reg == `SRAP_IDX_DAT_END) begin
            state_reg <= SRAP_D_TAIL;
          end
        end
        SRAP_D_TAIL: begin
          // closing zero bit; rearm the start detector
          state_reg <= SRAP_D_IDLE; // RL21 RL11 RL16
          idx_reg   <= `SRAP_IDX_ZERO;
          hist_reg  <= 3'h0;
        end
        default: begin
          state_reg <= SRAP_D_IDLE;
          idx_reg   <= `SRAP_IDX_ZERO;
          hist_reg  <= 3'h0;
        end
      endcase
    end
  end

  // ========================================================================
  // header field capture
  // ========================================================================
  always_ff @(negedge link.link_sck or negedge arst_n) begin
    if (!arst_n) begin
      shift_reg <= `SRAP_BYTE_ZERO;
      op_reg    <= SRAP_TARGETED_WRITE;
      rx_id_reg <= `SRAP_ID_ZERO;
      adr_reg   <= `SRAP_BYTE_ZERO;
    end else if (state_reg == SRAP_D_BODY || state_reg == SRAP_D_WDAT) begin
      shift_reg <= rx_byte;
      if (idx_reg == `SRAP_IDX_OP_END) begin
        op_reg <= srap_op_t'(rx_byte[1:0]); // RL6
      end
      // the two leading pad zeros are not checked
      if (idx_reg == `SRAP_IDX_ID_END) begin
        rx_id_reg <= rx_byte[5:0]; // RL7
      end
      if (idx_reg == `SRAP_IDX_ADR_END) begin
        adr_reg <= rx_byte; // RL8
      end
    end
  end

  // ========================================================================
  // control registers
  // ========================================================================
  // eight bits each; reserved bits are stored as written (zero) and are
  // not given reset values, being plain storage
  always_ff @(negedge link.link_sck) begin
    if (mem_we) begin
      regs[adr_reg] <= rx_byte; // RL10 RL19
    end
  end

  // ========================================================================
  // chain output driver
  // ========================================================================
  // the gap bit gives one edge to fetch the register and enable the driver;
  // during writes the driver stays off and chain input is ignored
  always_ff @(negedge link.link_sck or negedge arst_n) begin // RL13
    if (!arst_n) begin
      sdo_reg <= 1'b0;
      oe_reg  <= 1'b0;
      out_reg <= `SRAP_BYTE_ZERO;
    end else if (link.link_rst) begin
      sdo_reg <= 1'b0;
      oe_reg  <= 1'b0;
    end else begin
      unique case (state_reg)
        SRAP_D_BODY: begin
          if (idx_reg == `SRAP_IDX_GAP && (op_reg == SRAP_FORCED_READ
              || op_reg == SRAP_TARGETED_READ)) begin
            out_reg <= {regs[adr_reg][6:0], 1'b0};
            sdo_reg <= (op_reg == SRAP_TARGETED_READ && !id_match)
                       ? link.chain_input_pin : regs[adr_reg][7]; // RL15 RL14 RL18
            oe_reg  <= 1'b1;
          end
        end
        SRAP_D_RDAT: begin
          if (idx_reg != `SRAP_IDX_DAT_END) begin
            sdo_reg <= out_reg[7]; // RL15
            out_reg <= {out_reg[6:0], 1'b0};
          end
        end
        SRAP_D_PASS: begin
          // registered copy: one bit period of latency per stage
          sdo_reg <= link.chain_input_pin; // RL18
        end
        SRAP_D_TAIL: begin
          sdo_reg <= 1'b0;
          oe_reg  <= 1'b0; // RL21
        end
        default: begin
          sdo_reg <= sdo_reg;
        end
      endcase
    end
  end

  assign link.chain_output_pin = sdo_reg;
  assign link.chain_output_oe  = oe_reg;

  // ========================================================================
  // write notice towards the core domain
  // ========================================================================
  // address and data are held until the next write, at least 32 serial
  // edges away, which is ample for the toggle to cross
  always_ff @(negedge link.link_sck or negedge arst_n) begin
    if (!arst_n) begin
      wr_tog_reg  <= 1'b0;
      lat_adr_reg <= `SRAP_BYTE_ZERO;
      lat_dat_reg <= `SRAP_BYTE_ZERO;
    end else if (mem_we) begin
      wr_tog_reg  <= ~wr_tog_reg;
      lat_adr_reg <= adr_reg;
      lat_dat_reg <= rx_byte;
    end
  end

  logic tog_s1_reg;
  logic tog_s2_reg;
  logic tog_s3_reg;

  // toggle synchroniser; only the second and third flops feed the edge
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tog_s1_reg <= 1'b0;
      tog_s2_reg <= 1'b0;
      tog_s3_reg <= 1'b0;
    end else begin
      tog_s1_reg <= wr_tog_reg;
      tog_s2_reg <= tog_s1_reg;
      tog_s3_reg <= tog_s2_reg;
    end
  end

  // one-cycle strobe with the written address and byte
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_strobe <= 1'b0;
      wr_addr   <= `SRAP_BYTE_ZERO;
      wr_data   <= `SRAP_BYTE_ZERO;
    end else begin
      wr_strobe <= tog_s2_reg ^ tog_s3_reg;
      if (tog_s2_reg ^ tog_s3_reg) begin
        wr_addr <= lat_adr_reg;
        wr_data <= lat_dat_reg;
      end
    end
  end

endmodule

// ### verilog/srap_host.sv
// serial management controller: makes the link clock from core_clk / 2
`include "srap_consts.svh"
module srap_host
  import srap_pkg::*;
(
  srap_link_if.host         link,
  input  wire logic         core_clk,
  input  wire logic         arst_n,
  input  wire logic         req_valid,
  input  wire logic         req_init,
  input  wire logic [1:0]   req_op,
  input  wire logic [5:0]   req_id,
  input  wire logic [7:0]   req_addr,
  input  wire logic [7:0]   req_wdata,
  output logic              req_ready,
  output logic              rsp_valid,
  output logic [7:0]        rsp_rdata
);

  // ========================================================================
  // state
  // ========================================================================
  srap_host_state_t                 state_reg;
  logic                             sck_reg;
  logic                             cmd_reg;
  logic                             rst_reg;
  logic [5:0]                       pos_reg;
  logic [`SRAP_FRAME_W-1:0]         frame_reg;
  logic                             sdo_s1_reg;
  logic                             sdo_s2_reg;
  logic                             is_rd_reg;

  logic [`SRAP_FRAME_W-1:0]         frame_new;
  logic                             rise_now;

  // data slot carries zeros on reads; closing bit always zero
  assign frame_new = {`SRAP_LEAD, `SRAP_START, req_op, `SRAP_PAD_ID, req_id,
                      req_addr, `SRAP_GAP_BIT,
                      req_op[1] ? `SRAP_RD_FILL : req_wdata, `SRAP_END_BIT}; // RL5 RL14
  assign rise_now  = (state_reg == SRAP_H_RUN) && !sck_reg;

  // ========================================================================
  // sequencer and clock divider
  // ========================================================================
  // clock runs only during a frame and rests low otherwise (RL4)
  always_ff @(posedge core_clk or negedge arst_n) begin // RL3
    if (!arst_n) begin
      state_reg <= SRAP_H_IDLE;
      sck_reg   <= 1'b0;
      pos_reg   <= `SRAP_POS_ZERO;
      is_rd_reg <= 1'b0;
      rst_reg   <= 1'b0;
    end else begin
      unique case (state_reg)
        SRAP_H_IDLE: begin
          pos_reg <= `SRAP_POS_ZERO;
          if (req_init || req_valid) begin
            state_reg <= SRAP_H_RUN;
            is_rd_reg <= req_valid && !req_init && req_op[1];
            rst_reg   <= req_init; // RL1
          end
        end
        SRAP_H_RUN: begin
          sck_reg <= ~sck_reg;
          if (sck_reg) begin
            pos_reg <= pos_reg + `SRAP_POS_ONE;
            if (pos_reg == `SRAP_POS_LAST) begin
              state_reg <= SRAP_H_IDLE;
              rst_reg   <= 1'b0;
            end
          end
        end
        default: begin
          state_reg <= SRAP_H_IDLE;
        end
      endcase
    end
  end

  // ========================================================================
  // command shifter: changes on rising link edges, device samples falling
  // ========================================================================
  always_ff @(posedge core_clk or negedge arst_n) begin // RL2
    if (!arst_n) begin
      frame_reg <= '0;
      cmd_reg   <= 1'b0;
    end else if (state_reg == SRAP_H_IDLE) begin
      cmd_reg <= 1'b0;
      if (req_init) begin
        frame_reg <= '0;
      end else if (req_valid) begin
        frame_reg <= frame_new;
      end
    end else if (rise_now) begin
      cmd_reg   <= frame_reg[`SRAP_FRAME_W-1];
      frame_reg <= {frame_reg[`SRAP_FRAME_W-2:0], 1'b0}; // RL11 RL16
    end
  end

  // ========================================================================
  // read data capture
  // ========================================================================
  // sdo changes after the falling edge; through two flops it is read at the
  // second rising step after that, i.e. the bit of the previous position (RL15)
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sdo_s1_reg <= 1'b0;
      sdo_s2_reg <= 1'b0;
    end else begin
      sdo_s1_reg <= link.chain_line;
      sdo_s2_reg <= sdo_s1_reg;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_rdata <= `SRAP_BYTE_ZERO;
      rsp_valid <= 1'b0;
      req_ready <= 1'b0;
    end else begin
      if (rise_now && pos_reg >= `SRAP_POS_RD_FIRST) begin
        rsp_rdata <= {rsp_rdata[6:0], sdo_s2_reg}; // RL15 RL19
      end
      rsp_valid <= (state_reg == SRAP_H_RUN) && sck_reg
                   && (pos_reg == `SRAP_POS_LAST) && is_rd_reg;
      req_ready <= (state_reg == SRAP_H_IDLE) && !req_valid && !req_init;
    end
  end

  assign link.link_sck        = sck_reg;
  assign link.link_cmd        = cmd_reg;
  assign link.link_rst        = rst_reg;
  assign link.chain_input_pin = 1'b0; // RL13

endmodule

// ### verification/srap_link_chk.sv
// ==========================================================================
// link protocol checker, sampled in the core clock domain
// ==========================================================================
module srap_link_chk (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic link_sck,
  input wire logic link_cmd,
  input wire logic link_rst,
  input wire logic chain_input_pin,
  input wire logic chain_output_pin,
  input wire logic chain_output_oe,
  input wire logic chain_line
);
  logic       sck_q;
  logic [3:0] lo_run;
  logic [5:0] rise_cnt;
  logic [5:0] pos_now;
  logic [1:0] op_reg;
  logic [4:0] hi_cnt;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  // inside a frame sck is low for one sample only, so a longer low run marks a new frame
  assign pos_now = (lo_run >= 4'h2) ? 6'h00 : rise_cnt;

  // ==========================================================================
  // frame position tracking
  // ==========================================================================
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sck_q <= 1'b0;
      lo_run <= 4'h0;
    end else begin
      sck_q <= link_sck;
      lo_run <= link_sck ? 4'h0 : ((lo_run == 4'hF) ? lo_run : lo_run + 4'h1);
    end
  end

  // bit position counter and captured operation code
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rise_cnt <= 6'h00;
      op_reg <= 2'h0;
    end else if (link_sck && !sck_q) begin
      rise_cnt <= pos_now + 6'h01;
      if (pos_now == 6'h08) op_reg[1] <= link_cmd;
      if (pos_now == 6'h09) op_reg[0] <= link_cmd;
    end
  end

  // length of the current driver-enable burst
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) hi_cnt <= 5'h00;
    else hi_cnt <= chain_output_oe ? hi_cnt + 5'h01 : 5'h00;
  end

  AST_START_PAT: assert property ($rose(link_sck) && !link_rst && pos_now >= 6'h04 &&
    pos_now <= 6'h07 |-> link_cmd == (pos_now <= 6'h05)) else $error("bad start pattern");
  AST_PAD_ZERO: assert property ($rose(link_sck) && (pos_now == 6'h0A || pos_now == 6'h0B)
    |-> !link_cmd) else $error("pad bit not zero");
  AST_GAP_ZERO: assert property ($rose(link_sck) && pos_now == 6'h1A |-> !link_cmd)
    else $error("gap bit not zero");
  AST_END_ZERO: assert property ($rose(link_sck) && pos_now == 6'h23 |-> !link_cmd)
    else $error("final bit not zero");
  AST_RD_FILL: assert property ($rose(link_sck) && op_reg[1] && pos_now >= 6'h1B &&
    pos_now <= 6'h22 |-> !link_cmd) else $error("read fill not zero");
  AST_FRAME_LEN: assert property ($rose(link_sck) |-> pos_now <= 6'h23)
    else $error("frame longer than 36 periods");
  AST_OE_WRITE: assert property ($rose(chain_output_oe) |-> op_reg[1])
    else $error("driver enabled in a write");
  AST_OE_START: assert property ($rose(chain_output_oe) |-> $fell(link_sck) &&
    rise_cnt == 6'h1B) else $error("driver enabled at wrong edge");
  AST_OE_LEN: assert property ($fell(chain_output_oe) |-> hi_cnt == 5'h12)
    else $error("driver enable length wrong");
  AST_PIN_FALL: assert property ($changed(chain_output_pin) |-> $fell(link_sck))
    else $error("output changed off the falling edge");
endmodule

// ### verification/test_serial_register_access_port.sv
module test_serial_register_access_port import srap_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic       core_clk, arst_n, req_valid, req_init, req_ready, rsp_valid;
  logic [1:0] req_op;
  logic [5:0] req_id;
  logic [7:0] req_addr, req_wdata, rsp_rdata, last_rsp, pat;
  logic       wr_strobe_a, wr_strobe_b, prev_in, chk_pass;
  logic [7:0] wr_addr_a, wr_data_a, wr_addr_b, wr_data_b, wa_addr, wa_data, wb_data;
  int         n_mismatch, comparisons, n_wa, n_wb, n_rsp, n_pass;

  srap_link_if link();
  srap_link_if link_b();

  // second device shares the controller lines but gets its own chain input
  assign link_b.link_sck = link.link_sck;
  assign link_b.link_cmd = link.link_cmd;
  assign link_b.link_rst = link.link_rst;

  srap_host i_srap_host (.link(link.host), .core_clk(core_clk), .arst_n(arst_n),
    .req_valid(req_valid), .req_init(req_init), .req_op(req_op), .req_id(req_id),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  srap_dev i_srap_dev (.link(link.dev), .core_clk(core_clk), .arst_n(arst_n),
    .id_strap(6'h15), .wr_strobe(wr_strobe_a), .wr_addr(wr_addr_a), .wr_data(wr_data_a));
  srap_dev i_srap_dev_b (.link(link_b.dev), .core_clk(core_clk), .arst_n(arst_n),
    .id_strap(6'h2A), .wr_strobe(wr_strobe_b), .wr_addr(wr_addr_b), .wr_data(wr_data_b));
  srap_link_chk i_srap_link_chk (.core_clk(core_clk), .arst_n(arst_n),
    .link_sck(link.link_sck), .link_cmd(link.link_cmd), .link_rst(link.link_rst),
    .chain_input_pin(link.chain_input_pin), .chain_output_pin(link.chain_output_pin),
    .chain_output_oe(link.chain_output_oe), .chain_line(link.chain_line));

  // ==========================================================================
  // clock, monitors and chain stimulus
  // ==========================================================================
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // strobes and read answers are one-cycle pulses, so catch them every cycle
  always @(posedge core_clk) begin
    if (wr_strobe_a === 1'b1) begin
      n_wa++;
      wa_addr = wr_addr_a;
      wa_data = wr_data_a;
    end
    if (wr_strobe_b === 1'b1) begin
      n_wb++;
      wb_data = wr_data_b;
    end
    if (rsp_valid === 1'b1) begin
      n_rsp++;
      last_rsp = rsp_rdata;
    end
  end

  // a changing pattern on the chain input shows whether it is really copied
  always @(posedge link.link_sck) begin
    pat <= {pat[6:0], pat[7]};
    link_b.chain_input_pin <= pat[7];
  end

  // old output at a fall must equal the input sampled at the fall before
  always @(negedge link.link_sck) begin
    if (chk_pass && link_b.chain_output_oe === 1'b1 && n_pass < 8) begin
      n_pass++;
      cmp8({7'h00, link_b.chain_line}, {7'h00, prev_in});
    end
    prev_in <= link_b.chain_input_pin;
  end

  // ==========================================================================
  // shared tasks
  // ==========================================================================
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic step;
    @(posedge core_clk);
    #1;
  endtask

  // ready is advisory and lags, so wait a few cycles before trusting it
  task automatic wait_ready;
    int n;
    n = 0;
    while (req_ready !== 1'b1) begin
      step;
      n++;
      if (n > 200) begin
        n_mismatch++;
        end_of_test;
      end
    end
  endtask

  task automatic run_frame(input logic init, input srap_op_t op, input logic [5:0] id,
                           input logic [7:0] adr, input logic [7:0] wd);
    wait_ready;
    req_init = init;
    req_valid = !init;
    req_op = op;
    req_id = id;
    req_addr = adr;
    req_wdata = wd;
    step;
    req_valid = 1'b0;
    req_init = 1'b0;
    repeat (3) step;
    wait_ready;
    repeat (3) step;
  endtask

  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic sc_init;
    run_frame(1'b1, SRAP_TARGETED_WRITE, 6'h00, 8'h00, 8'h00);
    cmp8(n_wa[7:0] + n_wb[7:0], 8'h00);
  endtask

  task automatic sc_writes;
    run_frame(1'b0, SRAP_TARGETED_WRITE, 6'h15, 8'h3C, 8'hA5);
    cmp8(n_wa[7:0], 8'h01);
    cmp8(wa_addr, 8'h3C);
    cmp8(wa_data, 8'hA5);
    cmp8(n_wb[7:0], 8'h00);
    run_frame(1'b0, SRAP_BROADCAST_WRITE, 6'h3F, 8'h00, 8'h5A);
    cmp8(n_wa[7:0], 8'h02);
    cmp8(n_wb[7:0], 8'h01);
    cmp8(wb_data, 8'h5A);
    cmp8(wr_addr_b, 8'h00);
  endtask

  // targeted read of the first device while the second copies its chain
  task automatic sc_read_pass;
    chk_pass = 1'b1;
    run_frame(1'b0, SRAP_TARGETED_READ, 6'h15, 8'h3C, 8'h00);
    chk_pass = 1'b0;
    cmp8(n_rsp[7:0], 8'h01);
    cmp8(last_rsp, 8'hA5);
    cmp8(n_pass[7:0], 8'h08);
  endtask

  // mismatched read returns the controller's idle chain level, forced read answers
  task automatic sc_mismatch_forced;
    run_frame(1'b0, SRAP_TARGETED_READ, 6'h2A, 8'h00, 8'h00);
    cmp8(last_rsp, 8'h00);
    run_frame(1'b0, SRAP_FORCED_READ, 6'h3F, 8'h3C, 8'h00);
    cmp8(n_rsp[7:0], 8'h03);
    cmp8(last_rsp, 8'hA5);
  endtask

  // write then read of the same register, with the usual run_frame idle cycles between frames
  task automatic sc_back_to_back;
    run_frame(1'b0, SRAP_TARGETED_WRITE, 6'h15, 8'h81, 8'h7E);
    run_frame(1'b0, SRAP_TARGETED_READ, 6'h15, 8'h81, 8'h00);
    cmp8(wa_addr, 8'h81);
    cmp8(last_rsp, 8'h7E);
  endtask

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    arst_n = 1'b0;
    {req_valid, req_init, chk_pass, prev_in} = 4'h0;
    req_op = 2'h0;
    req_id = 6'h00;
    {req_addr, req_wdata, last_rsp} = 24'h000000;
    pat = 8'hD2;
    link_b.chain_input_pin = 1'b0;
    repeat (8) @(posedge core_clk);
    #1;
    cmp8({6'h00, link.link_sck, link.chain_output_oe}, 8'h00);
    cmp8({7'h00, req_ready}, 8'h00);
    arst_n = 1'b1;
    repeat (2) step;
    sc_init;
    sc_writes;
    sc_read_pass;
    sc_mismatch_forced;
    sc_back_to_back;
    end_of_test;
  end
endmodule
